//--- scan_filter_regs.svh
// constants of the analog scan filter block
`ifndef SCAN_FILTER_REGS_SVH
`define SCAN_FILTER_REGS_SVH
`define FILT_DATA_W 16
`define FILT_CODE_W 5
`define FILT_INSTANCES 31
`define FILT_DEPTH 5
`define FILT_DECIM 3'h4
`define FILT_MODE_COIL 3'h0
`define FILT_MODE_SMOOTH 3'h1
`define FILT_MODE_AVG 3'h2
`define FILT_MODE_MAX 3'h3
`define FILT_MODE_MIN 3'h4
`define FILT_OPT_TRIM 2'h1
`define FILT_OPT_MEAN 2'h2
`define FILT_OPT_MIDRANGE 2'h3
`define FILT_TB_X1 2'h0
`define FILT_TB_X10 2'h1
`define FILT_TB_X100 2'h2
`define FILT_FACTOR_X1 16'h0001
`define FILT_FACTOR_X10 16'h000a
`define FILT_FACTOR_X100 16'h0064
`define FILT_CUR_RESET 16'h0000
`endif

//--- scan_filter_pkg.sv
// types of the analog scan filter block
`include "scan_filter_regs.svh"
package scan_filter_pkg;
    typedef logic [`FILT_DATA_W-1:0] sample_t;
    typedef logic [`FILT_DEPTH-1:0][`FILT_DATA_W-1:0] window_t;
    typedef enum logic [2:0] {
        MODE_COIL = 3'h0,
        MODE_SMOOTH = 3'h1,
        MODE_AVG = 3'h3,
        MODE_MAX = 3'h2,
        MODE_MIN = 3'h6
    } mode_t;
    typedef struct packed {
        logic [`FILT_CODE_W-1:0] instance_code;
        logic [2:0] mode;
        logic [1:0] option;
        logic [1:0] time_base;
        logic [7:0] sample_count;
        logic enable;
        sample_t analog_source_input;
    } scan_req_t;
    typedef struct packed {
        logic [`FILT_CODE_W-1:0] instance_code;
        sample_t current_value;
        logic coil;
        logic refreshed;
    } scan_rsp_t;
endpackage

//--- analog_scan_filter_block.sv
// analog scan filter block: 31 smoothing instances served one scan request at a time
`timescale 1ns/1ps
`include "scan_filter_regs.svh"

module analog_scan_filter_block
    import scan_filter_pkg::*;
#(
    parameter int INSTANCES = `FILT_INSTANCES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic req_valid,
    input wire scan_req_t req,
    output logic rsp_valid,
    output scan_rsp_t rsp
);

    // ==========================================
    // elaboration check
    // the instance store is sized for the full set, so a larger count has no entries
    if (INSTANCES < 1 || INSTANCES > `FILT_INSTANCES) begin : bad_instances
        $error("INSTANCES must lie in 1..31");
    end
    // the saturating window counters are three bits wide
    if (`FILT_DEPTH > 7) begin : bad_depth
        $error("window depth must fit the three-bit counters");
    end

    // ==========================================
    // arithmetic helpers
    function automatic sample_t max5(input window_t w);
        sample_t m;
        m = w[0];
        for (int i = 1; i < `FILT_DEPTH; i++) begin
            if (w[i] > m) begin
                m = w[i];
            end
        end
        return m;
    endfunction

    function automatic sample_t min5(input window_t w);
        sample_t m;
        m = w[0];
        for (int i = 1; i < `FILT_DEPTH; i++) begin
            if (w[i] < m) begin
                m = w[i];
            end
        end
        return m;
    endfunction

    function automatic logic [`FILT_DATA_W+2:0] sum5(input window_t w);
        logic [`FILT_DATA_W+2:0] s;
        s = '0;
        for (int i = 0; i < `FILT_DEPTH; i++) begin
            s = s + {3'h0, w[i]};
        end
        return s;
    endfunction

    // drop largest and smallest, mean of the middle three
    function automatic sample_t trim_mean(input window_t w);
        logic [`FILT_DATA_W+2:0] s;
        s = sum5(w) - {3'h0, max5(w)} - {3'h0, min5(w)};
        return sample_t'(s / 3);
    endfunction

    // floor division, so the result never leaves the sample range
    function automatic sample_t mean5(input window_t w);
        logic [`FILT_DATA_W+2:0] s;
        s = sum5(w);
        return sample_t'(s / 5);
    endfunction

    function automatic sample_t midrange(input window_t w);
        logic [`FILT_DATA_W:0] s;
        s = {1'b0, max5(w)} + {1'b0, min5(w)};
        return sample_t'(s >> 1);
    endfunction

    // counters stop at the window depth so a long run cannot wrap them
    function automatic logic [2:0] sat_inc(input logic [2:0] n);
        return (n == 3'(`FILT_DEPTH)) ? n : n + 3'h1;
    endfunction

    // ==========================================
    // per-instance state, indexed by instance code
    // code 0 is unused so that codes map straight onto entries
    window_t raw_q [0:`FILT_INSTANCES];
    window_t trim_q [0:`FILT_INSTANCES];
    window_t mean_q [0:`FILT_INSTANCES];
    logic [2:0] raw_n_q [0:`FILT_INSTANCES];
    logic [2:0] trim_n_q [0:`FILT_INSTANCES];
    logic [2:0] mean_n_q [0:`FILT_INSTANCES];
    logic [2:0] ph5_q [0:`FILT_INSTANCES];
    logic [2:0] ph25_q [0:`FILT_INSTANCES];
    logic [31:0] acc_q [0:`FILT_INSTANCES];
    logic [23:0] cnt_q [0:`FILT_INSTANCES];
    sample_t cur_q [0:`FILT_INSTANCES];
    logic coil_q [0:`FILT_INSTANCES];
    logic en_prev_q [0:`FILT_INSTANCES];

    // ==========================================
    // request decode
    wire [`FILT_CODE_W-1:0] code = req.instance_code;
    wire code_ok = (code != '0) && (32'(code) <= INSTANCES);
    wire take = req_valid && code_ok;
    wire en = req.enable;
    wire sample_t x = req.analog_source_input;
    wire rise = en && !en_prev_q[code];
    wire [15:0] tb_factor = (req.time_base == `FILT_TB_X100) ? `FILT_FACTOR_X100 :
                            (req.time_base == `FILT_TB_X10) ? `FILT_FACTOR_X10 : `FILT_FACTOR_X1;
    wire [23:0] window_raw = {16'h0, req.sample_count} * {8'h0, tb_factor};
    // a zero window would divide by zero, so it is served as one scan
    wire [23:0] window_len = (window_raw == '0) ? 24'h1 : window_raw;

    // ==========================================
    // option decode for the three smoothing stages
    wire opt_trim = req.option == `FILT_OPT_TRIM;
    wire opt_mean = req.option == `FILT_OPT_MEAN;
    wire opt_mid = req.option == `FILT_OPT_MIDRANGE;

    // ==========================================
    // next state of the addressed instance
    window_t raw_d, trim_d, mean_d;
    logic [2:0] raw_n_d, trim_n_d, mean_n_d, ph5_d, ph25_d;
    logic [31:0] acc_d;
    logic [23:0] cnt_d;
    sample_t cur_d, tm, mn;
    logic coil_d, refresh_d;

    always_comb begin
        raw_d = raw_q[code];
        trim_d = trim_q[code];
        mean_d = mean_q[code];
        raw_n_d = raw_n_q[code];
        trim_n_d = trim_n_q[code];
        mean_n_d = mean_n_q[code];
        ph5_d = ph5_q[code];
        ph25_d = ph25_q[code];
        acc_d = acc_q[code];
        cnt_d = cnt_q[code];
        cur_d = cur_q[code];
        coil_d = coil_q[code];
        refresh_d = 1'b0;
        tm = '0;
        mn = '0;
        case (req.mode)
            `FILT_MODE_COIL: begin
                coil_d = en;
            end
            `FILT_MODE_SMOOTH: begin
                if (rise) begin
                    raw_n_d = 3'h0;
                    trim_n_d = 3'h0;
                    mean_n_d = 3'h0;
                    ph5_d = 3'h0;
                    ph25_d = 3'h0;
                end
                coil_d = en;
                if (en) begin
                    raw_d = {raw_d[`FILT_DEPTH-2:0], x};
                    raw_n_d = sat_inc(raw_n_d);
                    if (raw_n_d == 3'(`FILT_DEPTH)) begin
                        tm = trim_mean(raw_d);
                        trim_d = {trim_d[`FILT_DEPTH-2:0], tm};
                        trim_n_d = sat_inc(trim_n_d);
                        if (opt_trim) begin
                            cur_d = tm;
                            refresh_d = 1'b1;
                        end
                        ph5_d = (ph5_d == `FILT_DECIM) ? 3'h0 : ph5_d + 3'h1;
                        if (ph5_d == 3'h0 && trim_n_d == 3'(`FILT_DEPTH)) begin
                            mn = mean5(trim_d);
                            mean_d = {mean_d[`FILT_DEPTH-2:0], mn};
                            mean_n_d = sat_inc(mean_n_d);
                            if (opt_mean) begin
                                cur_d = mn;
                                refresh_d = 1'b1;
                            end
                            ph25_d = (ph25_d == `FILT_DECIM) ? 3'h0 : ph25_d + 3'h1;
                            if (ph25_d == 3'h0 && mean_n_d == 3'(`FILT_DEPTH)
                                && opt_mid) begin
                                cur_d = midrange(mean_d);
                                refresh_d = 1'b1;
                            end
                        end
                    end
                end
            end
            `FILT_MODE_AVG: begin
                coil_d = 1'b0;
                if (rise) begin
                    acc_d = '0;
                    cnt_d = '0;
                end
                if (en) begin
                    acc_d = acc_d + {16'h0, x};
                    cnt_d = cnt_d + 24'h1;
                    if (cnt_d >= window_len) begin
                        cur_d = sample_t'(acc_d / {8'h0, window_len});
                        acc_d = '0;
                        cnt_d = '0;
                        coil_d = 1'b1;
                        refresh_d = 1'b1;
                    end
                end
            end
            `FILT_MODE_MAX: begin
                coil_d = en;
                if (rise) begin
                    cur_d = x;
                end else if (en && x > cur_d) begin
                    cur_d = x;
                end
            end
            `FILT_MODE_MIN: begin
                coil_d = en;
                if (rise) begin
                    cur_d = x;
                end else if (en && x < cur_d) begin
                    cur_d = x;
                end
            end
            default: begin
                coil_d = 1'b0;
            end
        endcase
    end

    // ==========================================
    // state store; one instance written per request
    // refused codes never write, so they leave every instance untouched
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i <= `FILT_INSTANCES; i++) begin
                raw_n_q[i] <= 3'h0;
                trim_n_q[i] <= 3'h0;
                mean_n_q[i] <= 3'h0;
                ph5_q[i] <= 3'h0;
                ph25_q[i] <= 3'h0;
                acc_q[i] <= 32'h0;
                cnt_q[i] <= 24'h0;
                cur_q[i] <= `FILT_CUR_RESET;
                coil_q[i] <= 1'b0;
                en_prev_q[i] <= 1'b0;
                raw_q[i] <= '0;
                trim_q[i] <= '0;
                mean_q[i] <= '0;
            end
        end else if (take) begin
            raw_q[code] <= raw_d;
            trim_q[code] <= trim_d;
            mean_q[code] <= mean_d;
            raw_n_q[code] <= raw_n_d;
            trim_n_q[code] <= trim_n_d;
            mean_n_q[code] <= mean_n_d;
            ph5_q[code] <= ph5_d;
            ph25_q[code] <= ph25_d;
            acc_q[code] <= acc_d;
            cnt_q[code] <= cnt_d;
            cur_q[code] <= cur_d;
            coil_q[code] <= coil_d;
            en_prev_q[code] <= en;
        end
    end

    // ==========================================
    // answer, one cycle after the request
    // rsp keeps its last answer between accepted scans
    always_ff @(posedge clock) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= take;
            if (take) begin
                rsp.instance_code <= code;
                rsp.current_value <= cur_d;
                rsp.coil <= coil_d;
                rsp.refreshed <= refresh_d;
            end
        end
    end

endmodule

//--- analog_scan_filter_block_chk.sv
// port checker for the analog scan filter block
`timescale 1ns/1ps
module analog_scan_filter_block_chk
    import scan_filter_pkg::*;
#(
    parameter int INSTANCES = 31
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic req_valid,
    input wire scan_req_t req,
    input wire logic rsp_valid,
    input wire scan_rsp_t rsp
);
    // ========================================
    // request decode
    // no per-instance history here, so only relations within one scan are checked
    wire acc = req_valid && req.instance_code != 5'h00 && int'(req.instance_code) <= INSTANCES;
    wire avg = acc && req.mode == 3'h2;
    wire mx = acc && req.mode == 3'h3 && req.enable;
    wire mn = acc && req.mode == 3'h4 && req.enable;
    wire follow = acc && (req.mode == 3'h0 || req.mode == 3'h3 || req.mode == 3'h4);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ========================================
    // assertions and covers
    answer_once_a: assert property (acc |=> rsp_valid)
        else $error("accepted scan not answered");
    refused_code_a: assert property (!acc |=> !rsp_valid)
        else $error("answer without accepted scan");
    answer_code_a: assert property (acc |=> rsp.instance_code == $past(req.instance_code))
        else $error("answer carries wrong instance");
    coil_follow_a: assert property (follow |=> rsp.coil == $past(req.enable))
        else $error("coil does not follow enable");
    max_track_a: assert property (mx |=> rsp.current_value >= $past(req.analog_source_input))
        else $error("maximum below input");
    min_track_a: assert property (mn |=> rsp.current_value <= $past(req.analog_source_input))
        else $error("minimum above input");
    avg_pulse_a: assert property (avg |=> rsp.coil == rsp.refreshed)
        else $error("average coil not tied to refresh");
    avg_idle_a: assert property (avg && !req.enable |=> !rsp.coil && !rsp.refreshed)
        else $error("average refreshed while disabled");
    smooth_idle_a: assert property (acc && req.mode == 3'h1 && !req.enable |=> !rsp.refreshed)
        else $error("smoothing refreshed while disabled");
    trim_seen_c: cover property (acc && req.mode == 3'h1 ##1 rsp.refreshed);
    avg_pulse_c: cover property (avg ##1 rsp.coil);
    max_run_c: cover property (mx ##2 mx);
endmodule

bind analog_scan_filter_block analog_scan_filter_block_chk #(.INSTANCES(INSTANCES)) u_chk (
    .clock(clock),
    .srst(srst),
    .req_valid(req_valid),
    .req(req),
    .rsp_valid(rsp_valid),
    .rsp(rsp)
);

//--- analog_scan_filter_block_tb.sv
// self-checking bench for the analog scan filter block
`timescale 1ns/1ps
module analog_scan_filter_block_tb
    import scan_filter_pkg::*;
;
    // ========================================
    // stimulus state
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    scan_req_t req = '0;
    logic rsp_valid;
    scan_rsp_t rsp;
    int error_cnt = 0;
    int n_tests = 0;
    sample_t dat [11] = '{16'h00a1, 16'h0078, 16'h009a, 16'h00a0, 16'h00be, 16'h00a9,
        16'h006e, 16'h0079, 16'h0096, 16'h00c6, 16'h00c7};
    sample_t trim [7] = '{16'h009e, 16'h00a1, 16'h00a1, 16'h0096, 16'h0092, 16'h0092, 16'h009c};

    initial forever #2 clock = ~clock;

    analog_scan_filter_block u_analog_scan_filter_block (
        .clock(clock),
        .srst(srst),
        .req_valid(req_valid),
        .req(req),
        .rsp_valid(rsp_valid),
        .rsp(rsp)
    );

    // ========================================
    // access tasks
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [16:0] cv();
        return {rsp.coil, rsp.current_value};
    endfunction

    // one program scan; a gap cycle follows so the valid pulse never re-rises in one step
    task automatic scan(input logic [4:0] c, input logic [2:0] m, input logic [1:0] o, input logic [1:0] t,
            input logic [7:0] n, input logic en, input sample_t x);
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{c, m, o, t, n, en, x};
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        chk("answer", {16'h0000, c != 5'h00}, {16'h0000, rsp_valid});
        if (c != 5'h00) chk("code", {12'h000, c}, {12'h000, rsp.instance_code});
    endtask

    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ========================================
    // tests
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        #1;
        chk("reset", 17'h00000, {rsp_valid, rsp.current_value});
        for (int i = 0; i < 11; i++) begin
            scan(5'h02, 3'h1, 2'h1, 2'h0, 8'h00, 1'b1, dat[i]);
            chk("trim", i >= 4 ? {1'b1, trim[i < 4 ? 0 : i - 4]} : 17'h10000, cv());
            chk("trim refreshed", {16'h0000, i >= 4}, {16'h0000, rsp.refreshed});
            scan(5'h03, 3'h1, 2'h2, 2'h0, 8'h00, 1'b1, dat[i]);
            chk("mean", {1'b1, i >= 8 ? 16'h009b : 16'h0000}, cv());
        end
        for (int k = 1; k <= 29; k++) begin
            scan(5'h04, 3'h1, 2'h3, 2'h0, 8'h00, 1'b1, 16'(10 * k));
            if (k >= 28) chk("midrange", {1'b1, k == 29 ? 16'h0096 : 16'h0000}, cv());
        end
        scan(5'h07, 3'h2, 2'h0, 2'h0, 8'h03, 1'b1, 16'h000a);
        chk("avg first", 17'h00000, cv());
        scan(5'h07, 3'h2, 2'h0, 2'h0, 8'h03, 1'b1, 16'h0014);
        scan(5'h07, 3'h2, 2'h0, 2'h0, 8'h03, 1'b0, 16'h03e7);
        chk("avg paused", 17'h00000, cv());
        scan(5'h07, 3'h2, 2'h0, 2'h0, 8'h03, 1'b1, 16'h0021);
        chk("avg restart", 17'h00000, cv());
        scan(5'h07, 3'h2, 2'h0, 2'h0, 8'h03, 1'b1, 16'h0024);
        scan(5'h07, 3'h2, 2'h0, 2'h0, 8'h03, 1'b1, 16'h0027);
        chk("avg refresh", {1'b1, 16'h0024}, cv());
        chk("avg refreshed", 17'h00001, {16'h0000, rsp.refreshed});
        scan(5'h07, 3'h2, 2'h0, 2'h0, 8'h03, 1'b1, 16'h0030);
        chk("avg pulse end", 17'h00000, {rsp.coil, 15'h0000, rsp.refreshed});
        for (int k = 1; k <= 10; k++) begin
            scan(5'h08, 3'h2, 2'h0, 2'h1, 8'h01, 1'b1, 16'(k));
            if (k >= 9) chk("avg x10", {k == 10, k == 10 ? 16'h0005 : 16'h0000}, cv());
        end
        scan(5'h09, 3'h3, 2'h0, 2'h0, 8'h00, 1'b1, 16'h0032);
        chk("max load", {1'b1, 16'h0032}, cv());
        scan(5'h09, 3'h3, 2'h0, 2'h0, 8'h00, 1'b1, 16'h0046);
        scan(5'h09, 3'h3, 2'h0, 2'h0, 8'h00, 1'b1, 16'h0028);
        chk("max hold", {1'b1, 16'h0046}, cv());
        scan(5'h09, 3'h3, 2'h0, 2'h0, 8'h00, 1'b0, 16'h005a);
        chk("max off", {1'b0, 16'h0046}, cv());
        scan(5'h09, 3'h3, 2'h0, 2'h0, 8'h00, 1'b1, 16'h001e);
        chk("max restart", {1'b1, 16'h001e}, cv());
        scan(5'h0a, 3'h4, 2'h0, 2'h0, 8'h00, 1'b1, 16'h0032);
        scan(5'h0a, 3'h4, 2'h0, 2'h0, 8'h00, 1'b1, 16'h001e);
        scan(5'h0a, 3'h4, 2'h0, 2'h0, 8'h00, 1'b1, 16'h003c);
        chk("min hold", {1'b1, 16'h001e}, cv());
        scan(5'h0a, 3'h4, 2'h0, 2'h0, 8'h00, 1'b0, 16'h0005);
        chk("min off", {1'b0, 16'h001e}, cv());
        scan(5'h00, 3'h3, 2'h0, 2'h0, 8'h00, 1'b1, 16'h0063);
        chk("refused hold", {1'b0, 16'h001e}, cv());
        scan(5'h0b, 3'h0, 2'h0, 2'h0, 8'h00, 1'b1, 16'h004d);
        chk("aux on", 17'h10000, cv());
        scan(5'h0b, 3'h0, 2'h0, 2'h0, 8'h00, 1'b0, 16'h004d);
        chk("aux off", 17'h00000, cv());
        for (int k = 1; k <= 100; k++) begin
            scan(5'h0c, 3'h2, 2'h0, 2'h2, 8'h01, 1'b1, 16'(k));
            if (k >= 99) chk("avg x100", {k == 100, k == 100 ? 16'h0032 : 16'h0000}, cv());
        end
        scan(5'h0d, 3'h2, 2'h0, 2'h3, 8'h00, 1'b1, 16'h0055);
        chk("avg zero window", {1'b1, 16'h0055}, cv());
        scan(5'h0e, 3'h5, 2'h0, 2'h0, 8'h00, 1'b1, 16'h0044);
        chk("bad mode", 17'h00000, cv());
        for (int k = 1; k <= 5; k++) begin
            scan(5'h0f, 3'h1, 2'h0, 2'h0, 8'h00, 1'b1, 16'h0040);
        end
        chk("no option", 17'h10000, cv());
        chk("no option refreshed", 17'h00000, {16'h0000, rsp.refreshed});
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        #1;
        chk("reset again", 17'h00000, {rsp_valid, rsp.current_value});
        scan(5'h09, 3'h0, 2'h0, 2'h0, 8'h00, 1'b0, 16'h0011);
        chk("reset clears", 17'h00000, cv());
        close_out();
    end

    // a stalled handshake would otherwise hang the run
    initial begin
        repeat (4000) @(posedge clock);
        error_cnt++;
        close_out();
    end
endmodule
